// ===== hw/ctc_defines.vh
`ifndef CTC_DEFINES_VH
`define CTC_DEFINES_VH

// register byte offsets on the avalon slave
`define CTC_OFS_CTRL 5'h00
`define CTC_OFS_LOW_CMP 5'h04
`define CTC_OFS_ALT_CMP 5'h08
`define CTC_OFS_HIGH_CMP 5'h0c
`define CTC_OFS_CARRIER_OUT_CTRL 5'h10
`define CTC_OFS_COUNT 5'h14

// control register fields
`define CTC_CTRL_LOW_RUN 0
`define CTC_CTRL_HIGH_RUN 1
`define CTC_CTRL_LOW_OE 2
`define CTC_CTRL_HIGH_OE 3
`define CTC_CTRL_MODE_LSB 4
`define CTC_CTRL_MODE_MSB 5
`define CTC_CTRL_LSEL_LSB 8
`define CTC_CTRL_LSEL_MSB 9
`define CTC_CTRL_HSEL 12

// carrier output control fields
`define CTC_COC_ACTIVE_GATE 0
`define CTC_COC_NEXT_GATE 1
`define CTC_COC_REMOTE_SEL 2

// operating modes
`define CTC_MODE_OFF 2'h0
`define CTC_MODE_CASCADE 2'h1
`define CTC_MODE_CARRIER 2'h2
`define CTC_MODE_PWM 2'h3

// low count clock selections
`define CTC_LSEL_FAST 2'h0
`define CTC_LSEL_SLOW 2'h1
`define CTC_LSEL_EVENT 2'h2

// internal count clock dividers
`define CTC_DIV_FAST 8
`define CTC_DIV_SLOW 128
`define CTC_DIV_W 8

// reset values and the low counter maximum
`define CTC_ZERO8 8'h00
`define CTC_ZERO32 32'h0000_0000
`define CTC_CNT_MAX 8'hff

`endif

// ===== hw/ctc_prescale.v
`timescale 1ns/10ps
// free divider giving one-cycle count clock enables
module ctc_prescale #(
   parameter DIV = 8
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire run_i,
   output reg tick_o
);
   `include "ctc_defines.vh"
   localparam [`CTC_DIV_W-1:0] LAST = DIV[`CTC_DIV_W-1:0] - 1'b1;
   reg [`CTC_DIV_W-1:0] cnt_r;

   // count while running, restart from zero when stopped
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= {`CTC_DIV_W{1'b0}};
         tick_o <= 1'b0;
      end else if (!run_i) begin
         cnt_r <= {`CTC_DIV_W{1'b0}};
         tick_o <= 1'b0;
      end else begin
         tick_o <= (cnt_r == LAST);
         if (cnt_r == LAST) begin
            cnt_r <= {`CTC_DIV_W{1'b0}};
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule

// ===== hw/ctc_top.v
`timescale 1ns/10ps
// Function
// - cascade event mode counts pair on each valid event edge, low is LSB.
// - in cascade mode only low run starts and clears the pair.
// - dual match clears both to zero, raises only low match interrupt.
// - cascade square wave toggles low output on each dual match.
// - clearing low run forces square-wave output low.
// - low output starts low when its enable is set, except carrier remote select with active gate one.
// - carrier low-compare match: low irq, toggle, switch to alternate compare.
// - alternate-compare match: low irq, toggle, switch back to low compare.
// - carrier high match raises high irq and reloads active gate.
// - carrier reaches the low output only while active gate is one.
// - carrier control holds remote select bit2, next gate bit1, gate bit0.
// - active gate writes are accepted only while low output disabled.
// - pwm: low compare sets low width, alternate sets high width, clears.
module ctc_top (
   input wire clk_i,
   input wire rst_n_i,
   input wire [4:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   input wire event_input_i,
   output reg low_timer_out_o,
   output reg low_match_irq_o,
   output reg high_match_irq_o
);
   `include "ctc_defines.vh"

   // software registers
   reg low_run_r;
   reg high_run_r;
   reg low_out_enable_r;
   reg high_out_enable_r;
   reg [1:0] mode_r;
   reg [1:0] low_sel_r;
   reg high_sel_r;
   reg [7:0] low_compare_r;
   reg [7:0] alt_compare_r;
   reg [7:0] high_compare_r;
   reg remote_out_select_r;
   reg next_gate_buffer_r;
   reg active_gate_r;

   // timer state
   reg [7:0] low_counter_r;
   reg [7:0] high_counter_r;
   reg use_alt_r;
   reg wave_r;
   reg event_prev_r;
   reg low_run_prev_r;

   wire req = avs_read_i | avs_write_i;
   wire wr_take = avs_write_i & ~avs_waitrequest_o;
   wire be0 = avs_byteenable_i[0];
   wire be1 = avs_byteenable_i[1];
   wire wr_ctrl = wr_take & (avs_address_i == `CTC_OFS_CTRL);
   wire wr_coc = wr_take & be0 &
      (avs_address_i == `CTC_OFS_CARRIER_OUT_CTRL);

   wire cascade = (mode_r == `CTC_MODE_CASCADE);
   wire carrier = (mode_r == `CTC_MODE_CARRIER);
   wire pwm = (mode_r == `CTC_MODE_PWM);
   wire high_active = carrier & high_run_r & low_run_r;

   // count clock enables from the dividers and the event pin
   wire fast_tick;
   wire slow_tick;
   wire hfast_tick;
   wire hslow_tick;
   wire event_edge = event_input_i & ~event_prev_r & low_run_r;
   reg low_tick;
   wire high_tick = high_sel_r ? hslow_tick : hfast_tick;

   ctc_prescale #(
      .DIV(`CTC_DIV_FAST)
   ) u_low_fast (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(low_run_r),
      .tick_o(fast_tick)
   );

   ctc_prescale #(
      .DIV(`CTC_DIV_SLOW)
   ) u_low_slow (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(low_run_r),
      .tick_o(slow_tick)
   );

   ctc_prescale #(
      .DIV(`CTC_DIV_FAST)
   ) u_high_fast (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(high_active),
      .tick_o(hfast_tick)
   );

   ctc_prescale #(
      .DIV(`CTC_DIV_SLOW)
   ) u_high_slow (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(high_active),
      .tick_o(hslow_tick)
   );

   // low count clock selection
   always @* begin
      case (low_sel_r)
         `CTC_LSEL_FAST: low_tick = fast_tick;
         `CTC_LSEL_SLOW: low_tick = slow_tick;
         `CTC_LSEL_EVENT: low_tick = event_edge;
         default: low_tick = 1'b0;
      endcase
   end

   // match detection
   wire [7:0] act_cmp = use_alt_r ? alt_compare_r : low_compare_r;
   wire dual_match = (low_counter_r == low_compare_r) &
      (high_counter_r == high_compare_r);
   wire cas_hit = cascade & low_run_r & low_tick & dual_match;
   wire lo_hit = (carrier | pwm) & low_run_r & low_tick &
      (low_counter_r == act_cmp);
   wire hi_hit = high_active & high_tick &
      (high_counter_r == high_compare_r);

   // counter pair
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_counter_r <= `CTC_ZERO8;
         high_counter_r <= `CTC_ZERO8;
         use_alt_r <= 1'b0;
      end else if (cascade) begin
         // high run is ignored here
         if (!low_run_r) begin
            low_counter_r <= `CTC_ZERO8;
            high_counter_r <= `CTC_ZERO8;
         end else if (cas_hit) begin
            low_counter_r <= `CTC_ZERO8;
            high_counter_r <= `CTC_ZERO8;
         end else if (low_tick) begin
            low_counter_r <= low_counter_r + 1'b1;
            if (low_counter_r == `CTC_CNT_MAX) begin
               high_counter_r <= high_counter_r + 1'b1;
            end
         end
         use_alt_r <= 1'b0;
      end else begin
         // low timer: alternating compare, clear on each match
         if (!low_run_r) begin
            low_counter_r <= `CTC_ZERO8;
            use_alt_r <= 1'b0;
         end else if (lo_hit) begin
            low_counter_r <= `CTC_ZERO8;
            use_alt_r <= ~use_alt_r;
         end else if (low_tick) begin
            low_counter_r <= low_counter_r + 1'b1;
         end
         // high timer sets the gating period in carrier mode
         if (!high_active) begin
            high_counter_r <= `CTC_ZERO8;
         end else if (hi_hit) begin
            high_counter_r <= `CTC_ZERO8;
         end else if (high_tick) begin
            high_counter_r <= high_counter_r + 1'b1;
         end
      end
   end

   // raw wave: toggles on matches, low when stopped or disabled
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wave_r <= 1'b0;
      end else if (!low_run_r || !low_out_enable_r) begin
         wave_r <= 1'b0;
      end else if (cas_hit) begin
         wave_r <= ~wave_r;
      end else if (lo_hit) begin
         wave_r <= ~wave_r;
      end
   end

   // pin output, gated by the active gate in carrier mode
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_timer_out_o <= 1'b0;
      end else if (!low_out_enable_r || !low_run_r) begin
         low_timer_out_o <= 1'b0;
      end else if (carrier) begin
         if (remote_out_select_r) begin
            low_timer_out_o <= active_gate_r;
         end else begin
            low_timer_out_o <= wave_r & active_gate_r;
         end
      end else begin
         low_timer_out_o <= wave_r;
      end
   end

   // match pulses, only the low one in cascade mode
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_match_irq_o <= 1'b0;
         high_match_irq_o <= 1'b0;
      end else begin
         low_match_irq_o <= cas_hit | lo_hit;
         high_match_irq_o <= hi_hit;
      end
   end

   // carrier output control bits
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         remote_out_select_r <= 1'b0;
         next_gate_buffer_r <= 1'b0;
         active_gate_r <= 1'b0;
      end else begin
         if (wr_coc) begin
            remote_out_select_r <=
               avs_writedata_i[`CTC_COC_REMOTE_SEL];
            next_gate_buffer_r <= avs_writedata_i[`CTC_COC_NEXT_GATE];
         end else if (carrier && low_run_prev_r && !low_run_r) begin
            next_gate_buffer_r <= 1'b0; // not kept across a stop
         end
         // reload at high match wins over a software write
         if (hi_hit) begin
            active_gate_r <= next_gate_buffer_r;
         end else if (wr_coc && !low_out_enable_r) begin
            active_gate_r <=
               avs_writedata_i[`CTC_COC_ACTIVE_GATE];
         end
      end
   end

   // control and compare registers
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_run_r <= 1'b0;
         high_run_r <= 1'b0;
         low_out_enable_r <= 1'b0;
         high_out_enable_r <= 1'b0;
         mode_r <= `CTC_MODE_OFF;
         low_sel_r <= `CTC_LSEL_FAST;
         high_sel_r <= 1'b0;
         low_compare_r <= `CTC_ZERO8;
         alt_compare_r <= `CTC_ZERO8;
         high_compare_r <= `CTC_ZERO8;
      end else begin
         if (wr_ctrl && be0) begin
            low_run_r <= avs_writedata_i[`CTC_CTRL_LOW_RUN];
            high_run_r <= avs_writedata_i[`CTC_CTRL_HIGH_RUN];
            low_out_enable_r <= avs_writedata_i[`CTC_CTRL_LOW_OE];
            high_out_enable_r <= avs_writedata_i[`CTC_CTRL_HIGH_OE];
            mode_r <=
               avs_writedata_i[`CTC_CTRL_MODE_MSB:`CTC_CTRL_MODE_LSB];
         end
         if (wr_ctrl && be1) begin
            low_sel_r <=
               avs_writedata_i[`CTC_CTRL_LSEL_MSB:`CTC_CTRL_LSEL_LSB];
            high_sel_r <= avs_writedata_i[`CTC_CTRL_HSEL];
         end
         if (wr_take && be0) begin
            case (avs_address_i)
               `CTC_OFS_LOW_CMP: low_compare_r <= avs_writedata_i[7:0];
               `CTC_OFS_ALT_CMP: alt_compare_r <= avs_writedata_i[7:0];
               `CTC_OFS_HIGH_CMP: high_compare_r <= avs_writedata_i[7:0];
               default: ;
            endcase
         end
      end
   end

   // run edge history for the stop detect and the event edge
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_run_prev_r <= 1'b0;
         event_prev_r <= 1'b0;
      end else begin
         low_run_prev_r <= low_run_r;
         event_prev_r <= event_input_i;
      end
   end

   // read mux
   reg [31:0] rd_nxt;
   always @* begin
      rd_nxt = `CTC_ZERO32;
      case (avs_address_i)
         `CTC_OFS_CTRL: begin
            rd_nxt[`CTC_CTRL_LOW_RUN] = low_run_r;
            rd_nxt[`CTC_CTRL_HIGH_RUN] = high_run_r;
            rd_nxt[`CTC_CTRL_LOW_OE] = low_out_enable_r;
            rd_nxt[`CTC_CTRL_HIGH_OE] = high_out_enable_r;
            rd_nxt[`CTC_CTRL_MODE_MSB:`CTC_CTRL_MODE_LSB] = mode_r;
            rd_nxt[`CTC_CTRL_LSEL_MSB:`CTC_CTRL_LSEL_LSB] = low_sel_r;
            rd_nxt[`CTC_CTRL_HSEL] = high_sel_r;
         end
         `CTC_OFS_LOW_CMP: rd_nxt[7:0] = low_compare_r;
         `CTC_OFS_ALT_CMP: rd_nxt[7:0] = alt_compare_r;
         `CTC_OFS_HIGH_CMP: rd_nxt[7:0] = high_compare_r;
         `CTC_OFS_CARRIER_OUT_CTRL: begin
            rd_nxt[`CTC_COC_REMOTE_SEL] = remote_out_select_r;
            rd_nxt[`CTC_COC_NEXT_GATE] = next_gate_buffer_r;
            rd_nxt[`CTC_COC_ACTIVE_GATE] = active_gate_r;
         end
         `CTC_OFS_COUNT: rd_nxt[15:0] = {high_counter_r, low_counter_r};
         default: rd_nxt = `CTC_ZERO32;
      endcase
   end

   // one wait state per access, data captured with it
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= `CTC_ZERO32;
      end else begin
         avs_waitrequest_o <= ~(req & avs_waitrequest_o);
         if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rd_nxt;
         end
      end
   end
endmodule

// ===== testbench/ctc_top_monitor.sv
`timescale 1ns/10ps
`include "ctc_defines.vh"
module ctc_top_monitor (
   input wire clk_i,
   input wire rst_n_i,
   input wire [4:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire event_input_i,
   input wire low_timer_out_o,
   input wire low_match_irq_o,
   input wire high_match_irq_o
);
   reg [7:0] ctrl_r;
   wire run = ctrl_r[0];
   wire oe = ctrl_r[2];
   wire [1:0] mode = ctrl_r[5:4];
   // shadow of the low control byte, taken at write completion
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= 8'h00;
      end else if (avs_write_i && !avs_waitrequest_o &&
                   avs_address_i == `CTC_OFS_CTRL && avs_byteenable_i[0]) begin
         ctrl_r <= avs_writedata_i[7:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // bus handshake and refusals
   a_bus_answer: assert property ($rose(avs_read_i || avs_write_i)
      |=> !avs_waitrequest_o) else $error("bus not answered");
   a_bus_idle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o &&
      avs_address_i > 5'h14 |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   // output forcing and interrupt gating
   a_stop_out_low: assert property (!run [*3] |-> !low_timer_out_o)
      else $error("output high while stopped");
   a_oe_off_low: assert property (!oe [*3] |-> !low_timer_out_o)
      else $error("output high while disabled");
   a_stop_no_irq: assert property (!run [*3] |->
      !low_match_irq_o && !high_match_irq_o) else $error("irq while stopped");
   a_cascade_no_high: assert property ((mode == `CTC_MODE_CASCADE) [*3]
      |-> !high_match_irq_o) else $error("high irq in cascade");
   // toggles tied to matches
   a_toggle_cause: assert property (mode != `CTC_MODE_CARRIER && run && oe
      && $past(run && oe, 3) && $changed(low_timer_out_o)
      |-> $past(low_match_irq_o)) else $error("toggle without match");
   a_pwm_toggle: assert property (mode == `CTC_MODE_PWM && run && oe
      && low_match_irq_o |=> $changed(low_timer_out_o))
      else $error("pwm match without toggle");
   c_cascade: cover property (mode == `CTC_MODE_CASCADE && low_match_irq_o);
   c_high: cover property (high_match_irq_o);
   c_pwm: cover property (mode == `CTC_MODE_PWM && $rose(low_timer_out_o));
endmodule
bind ctc_top ctc_top_monitor u_mon (.clk_i, .rst_n_i, .avs_address_i,
   .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
   .avs_readdata_o, .avs_waitrequest_o, .event_input_i, .low_timer_out_o,
   .low_match_irq_o, .high_match_irq_o);

// ===== testbench/ctc_pulse_src.sv
`timescale 1ns/10ps
module ctc_pulse_src (
   input wire clk_i,
   input wire rst_n_i,
   input wire go_i,
   input wire [8:0] n_i,
   input wire [1:0] slow_i,
   output reg event_o,
   output reg busy_o
);
   reg [8:0] left_r;
   reg [1:0] ph_r;
   // n pulses, each level held 1 + slow_i cycles, line low when idle
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         event_o <= 1'b0;
         busy_o <= 1'b0;
         left_r <= 9'h000;
         ph_r <= 2'h0;
      end else if (go_i && !busy_o) begin
         left_r <= n_i;
         busy_o <= (n_i != 9'h000);
         ph_r <= 2'h0;
      end else if (busy_o) begin
         if (ph_r == slow_i) begin
            ph_r <= 2'h0;
            event_o <= !event_o;
            if (event_o) begin
               left_r <= left_r - 9'h001;
               busy_o <= (left_r != 9'h001);
            end
         end else begin
            ph_r <= ph_r + 2'h1;
         end
      end
   end
endmodule

// ===== testbench/ctc_top_tb.sv
`timescale 1ns/10ps
`include "ctc_defines.vh"
module ctc_top_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [4:0] avs_address_i = 5'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o, event_input_i, low_timer_out_o;
   logic low_match_irq_o, high_match_irq_o, busy;
   logic go = 1'b0;
   logic [8:0] n = 9'h000;
   logic [1:0] slow = 2'h0;
   logic [31:0] seed = 32'd74;
   logic [31:0] q[$];
   int fails = 0, checked = 0, cyc = 0, nlo = 0, nhi = 0;
   ctc_top dut (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .event_input_i, .low_timer_out_o,
      .low_match_irq_o, .high_match_irq_o);
   ctc_pulse_src src (.clk_i, .rst_n_i, .go_i(go), .n_i(n), .slow_i(slow),
      .event_o(event_input_i), .busy_o(busy));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("Error %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task final_report;
      $display("fails %0d checked %0d", fails, checked);
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // bus cycles held until waitrequest is seen low
   task bw(input logic [4:0] a, input logic [31:0] d);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= 1'b1;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
      avs_write_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task br(input logic [4:0] a, input logic [31:0] e);
      q.push_back(e);
      avs_address_i <= a;
      avs_read_i <= 1'b1;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
      avs_read_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task pulses(input int k);
      logic [31:0] r;
      r = rnd();
      n <= k[8:0];
      slow <= r[1:0];
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      while (busy) @(posedge clk_i);
      repeat (3) @(posedge clk_i);
   endtask
   // count cycles while the pin stays at v
   task wlev(input logic v, output int k);
      k = 0;
      while (low_timer_out_o === v && k < 500) begin
         @(posedge clk_i);
         k++;
      end
   endtask
   task measure(input int hi, input int lo);
      int k;
      wlev(1'b1, k);
      wlev(1'b0, k);
      wlev(1'b1, k);
      chk(k, hi);
      wlev(1'b0, k);
      chk(k, lo);
   endtask
   task wirq(input logic hi);
      int k;
      k = 0;
      while ((hi ? high_match_irq_o : low_match_irq_o) !== 1'b1 && k < 300) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 300) begin
         fails++;
         $display("Error %0t: match pulse never came", $time);
      end
   endtask
   // read scoreboard and interrupt counters
   always @(posedge clk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0)
         chk(avs_readdata_o, q.pop_front());
      if (low_match_irq_o === 1'b1) nlo++;
      if (high_match_irq_o === 1'b1) nhi++;
   end
   // hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report;
      end
   end
   initial begin : main
      int i;
      logic [31:0] r;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      // reset values, unmapped slot, compare read back
      for (i = 0; i <= 24; i += 4) br(i[4:0], 32'h0);
      bw(5'h18, 32'hffffffff);
      br(5'h18, 32'h0);
      r = rnd();
      bw(`CTC_OFS_LOW_CMP, r);
      br(`CTC_OFS_LOW_CMP, {24'h0, r[7:0]});
      // cascade event counting, high run alone counts nothing
      bw(`CTC_OFS_CTRL, 32'h0212);
      bw(`CTC_OFS_LOW_CMP, 32'h01);
      bw(`CTC_OFS_HIGH_CMP, 32'h01);
      pulses(4);
      br(`CTC_OFS_COUNT, 32'h0);
      bw(`CTC_OFS_CTRL, 32'h0211);
      pulses(256);
      br(`CTC_OFS_COUNT, 32'h0100);
      pulses(1);
      br(`CTC_OFS_COUNT, 32'h0101);
      chk(nlo, 0);
      pulses(1);
      br(`CTC_OFS_COUNT, 32'h0);
      chk(nlo, 1);
      chk(nhi, 0);
      // cascade square wave, high output kept off
      bw(`CTC_OFS_CTRL, 32'h0210);
      bw(`CTC_OFS_LOW_CMP, 32'h03);
      bw(`CTC_OFS_HIGH_CMP, 32'h00);
      bw(`CTC_OFS_CTRL, 32'h0014);
      bw(`CTC_OFS_CTRL, 32'h0015);
      measure(32, 32);
      bw(`CTC_OFS_CTRL, 32'h0014);
      repeat (3) @(posedge clk_i);
      chk(low_timer_out_o, 1'b0);
      // carrier: gate closed first, reload opens it
      bw(`CTC_OFS_CTRL, 32'h0);
      bw(`CTC_OFS_LOW_CMP, 32'h02);
      bw(`CTC_OFS_ALT_CMP, 32'h03);
      bw(`CTC_OFS_HIGH_CMP, 32'h04);
      bw(`CTC_OFS_CARRIER_OUT_CTRL, 32'h02);
      bw(`CTC_OFS_CTRL, 32'h0020);
      br(`CTC_OFS_CARRIER_OUT_CTRL, 32'h02);
      bw(`CTC_OFS_CTRL, 32'h0027);
      wirq(1'b0);
      repeat (3) @(posedge clk_i);
      chk(low_timer_out_o, 1'b0);
      wirq(1'b1);
      repeat (12) @(posedge clk_i);
      br(`CTC_OFS_CARRIER_OUT_CTRL, 32'h03);
      measure(32, 24);
      wirq(1'b1);
      repeat (12) @(posedge clk_i);
      bw(`CTC_OFS_CARRIER_OUT_CTRL, 32'h04);
      br(`CTC_OFS_CARRIER_OUT_CTRL, 32'h05);
      repeat (3) @(posedge clk_i);
      chk(low_timer_out_o, 1'b1);
      bw(`CTC_OFS_CTRL, 32'h0);
      bw(`CTC_OFS_CARRIER_OUT_CTRL, 32'h00);
      br(`CTC_OFS_CARRIER_OUT_CTRL, 32'h00);
      // pwm widths, output starts low
      bw(`CTC_OFS_LOW_CMP, 32'h01);
      bw(`CTC_OFS_ALT_CMP, 32'h02);
      bw(`CTC_OFS_CTRL, 32'h0034);
      repeat (3) @(posedge clk_i);
      chk(low_timer_out_o, 1'b0);
      bw(`CTC_OFS_CTRL, 32'h0035);
      measure(24, 16);
      bw(`CTC_OFS_CTRL, 32'h0);
      final_report;
   end
endmodule
